// File: pkg/mmc_consts.svh
// Summary of operation
// - Retry, collision, FCS and port fields accessible only while stopped or suspended.
// - Internal loopback bit accessible only while stopped, not merely suspended.
// - Port select bits 8-7: AUI, twisted pair, serial, reserved; gated by media bit.
// - Hardware reset clears port select and the shared threshold/idle bit.
// - Retry disable gives one attempt; otherwise sixteen attempts then retry error.
// - Collision force in internal loopback collides every attempt, ending in retry error.
// - FCS disable clear appends FCS; set sends none and gives CRC to receiver.
// - Descriptor FCS force bit appends FCS regardless of the disable bit.
// - Idle level bit picks AUI idle state only for manual AUI selection.
// - Low threshold bit acts only when twisted pair port is selected.
// - Codec loopback bit 10 picks whether internal loopback includes the codec.
// - Loopback decode: off normal, external, internal with or without codec.
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH
`define MMC_BIT_CODEC_LB 10
`define MMC_BIT_LRT_AUI_IDLE_LEVEL_SEL 9
`define MMC_BIT_PORT_HI 8
`define MMC_BIT_PORT_LO 7
`define MMC_BIT_INT_LB 6
`define MMC_BIT_RETRY_DIS 5
`define MMC_BIT_COLL_FORCE 4
`define MMC_BIT_FCS_DIS 3
`define MMC_BIT_LB_EN 2
`define MMC_BIT_TX_DIS 1
`define MMC_BIT_RX_DIS 0
`define MMC_MODE_RESET 16'h0000
`define MMC_MAX_ATTEMPTS 5'h10
`endif

// File: pkg/mmc_pkg.sv
package mmc_pkg;
  typedef enum logic [1:0] {MMC_PORT_AUI, MMC_PORT_TP, MMC_PORT_GENERAL_SERIAL_PORT, MMC_PORT_RSVD} mmc_port_t;
  typedef enum logic [1:0] {MMC_LB_NONE, MMC_LB_EXT, MMC_LB_INT_CODEC, MMC_LB_INT_NOCODEC} mmc_lb_t;
  // Decoded mode for the medium side
  typedef struct packed {
    mmc_port_t port;
    mmc_lb_t lb;
    logic low_thresh;
    logic aui_idle_high;
    logic coll_force;
    logic fcs_to_rx;
  } mmc_media_t;
  // Frame outcome toward the transmit engine
  typedef struct packed {
    logic done;
    logic ok;
    logic retry_err;
    logic fcs_append;
  } mmc_tx_res_t;
endpackage : mmc_pkg

// File: hw/mmc_mode_decode.sv
`timescale 1ns/1ps
`include "mmc_consts.svh"
module mmc_mode_decode
  import mmc_pkg::*;
(
  input wire logic [15:0] i_mode, // Stored mode word
  input wire logic i_media_sel, // Automatic media select bit
  output mmc_media_t o_media // Decoded medium settings
);
  mmc_port_t port;
  mmc_lb_t lb;

  // Port and loopback decode
  always_comb
  begin
    port = i_media_sel ? MMC_PORT_AUI : mmc_port_t'(i_mode[`MMC_BIT_PORT_HI:`MMC_BIT_PORT_LO]);
    if (!i_mode[`MMC_BIT_LB_EN])
      lb = MMC_LB_NONE;
    else if (!i_mode[`MMC_BIT_INT_LB])
      lb = MMC_LB_EXT;
    else if (!i_mode[`MMC_BIT_CODEC_LB])
      lb = MMC_LB_INT_CODEC;
    else
      lb = MMC_LB_INT_NOCODEC;
  end

  // Qualified settings
  always_comb
  begin
    o_media.port = port;
    o_media.lb = lb;
    o_media.low_thresh = i_mode[`MMC_BIT_LRT_AUI_IDLE_LEVEL_SEL] && !i_media_sel && port == MMC_PORT_TP;
    o_media.aui_idle_high = i_mode[`MMC_BIT_LRT_AUI_IDLE_LEVEL_SEL] && !i_media_sel && port == MMC_PORT_AUI;
    o_media.coll_force = i_mode[`MMC_BIT_COLL_FORCE] && (lb == MMC_LB_INT_CODEC || lb == MMC_LB_INT_NOCODEC);
    o_media.fcs_to_rx = i_mode[`MMC_BIT_FCS_DIS];
  end
endmodule : mmc_mode_decode

// File: hw/mmc_retry_ctl.sv
`timescale 1ns/1ps
`include "mmc_consts.svh"
module mmc_retry_ctl
  import mmc_pkg::*;
(
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Synchronised reset
  input wire logic i_start, // Frame start pulse
  input wire logic i_frame_fcs_force, // Descriptor FCS force bit
  input wire logic i_fcs_dis, // Mode FCS disable
  input wire logic i_retry_dis, // Mode retry disable
  input wire logic i_coll_force, // Qualified collision force
  input wire logic i_att_end, // Attempt end pulse
  input wire logic i_att_coll, // Attempt collided
  output logic o_busy, // Frame in progress
  output logic o_retry_att, // Request another attempt
  output mmc_tx_res_t o_res // Frame outcome
);
  logic [4:0] att_q;
  logic fcs_q;
  logic coll;
  logic last;

  assign coll = i_att_coll || i_coll_force;
  assign last = i_retry_dis || att_q == `MMC_MAX_ATTEMPTS;
  assign o_retry_att = o_busy && i_att_end && coll && !last;

  // Attempt counter
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_busy <= 1'b0;
      att_q <= 5'h00;
    end
    else if (!o_busy && i_start)
    begin
      o_busy <= 1'b1;
      att_q <= 5'h01;
    end
    else if (o_busy && i_att_end)
    begin
      if (coll && !last)
        att_q <= att_q + 5'h01;
      else
        o_busy <= 1'b0;
    end
  end

  // Per-frame FCS decision
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fcs_q <= 1'b0;
    else if (!o_busy && i_start)
      fcs_q <= i_frame_fcs_force || !i_fcs_dis;
  end

  // Outcome registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_res <= '0;
    else
    begin
      o_res.done <= o_busy && i_att_end && !(coll && !last);
      o_res.ok <= o_busy && i_att_end && !coll;
      o_res.retry_err <= o_busy && i_att_end && coll && last;
      o_res.fcs_append <= fcs_q;
    end
  end

  AST_ONE_ATTEMPT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_busy && i_att_end && i_retry_dis |-> !o_retry_att ##1 !o_busy)
    else $error("retry issued with retry disabled");
  AST_MAX_ATT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    att_q <= `MMC_MAX_ATTEMPTS)
    else $error("attempt count above limit");
  AST_COLL_FAIL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_busy && i_att_end && i_coll_force |=> !o_res.ok)
    else $error("success under forced collision");
  AST_FCS_FORCE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_busy && i_start && i_frame_fcs_force |=> ##1 o_res.fcs_append)
    else $error("forced FCS not appended");
  AST_FCS_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_busy && i_start && i_fcs_dis && !i_frame_fcs_force |=> ##1 !o_res.fcs_append)
    else $error("FCS appended while disabled");
endmodule : mmc_retry_ctl

// File: hw/mmc_mode_ctrl.sv
`timescale 1ns/1ps
`include "mmc_consts.svh"
module mmc_mode_ctrl
  import mmc_pkg::*;
(
  input wire logic i_ref_clk, // Core clock, 20 MHz
  input wire logic i_arst_n, // Asynchronous reset, active low
  input wire logic i_stop, // Controller stopped
  input wire logic i_suspend, // Controller suspended
  input wire logic i_media_sel, // Automatic media select bit
  input wire logic i_init_load, // Load mode from initialization block
  input wire logic [15:0] i_init_mode, // Initialization block mode word
  input wire logic i_wr, // Register write strobe
  input wire logic [15:0] i_wdata, // Register write data
  output logic [15:0] o_rdata, // Register read data
  input wire logic i_tx_start, // Frame start pulse
  input wire logic i_frame_fcs_force, // Descriptor FCS force bit
  input wire logic i_att_end, // Attempt end pulse
  input wire logic i_att_coll, // Attempt saw collision
  output logic o_wr_refused, // Write ignored this cycle
  output logic o_tx_busy, // Frame in progress
  output logic o_retry_att, // Request next attempt
  output mmc_tx_res_t o_tx_res, // Frame outcome
  output mmc_media_t o_media, // Medium settings
  output logic o_tx_dis, // Transmit disabled
  output logic o_rx_dis // Receive disabled
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [15:0] mode_q;
  logic [15:0] mode_d;
  logic stop_ok;
  logic suspend_flag_ok;
  logic wr_ok;
  mmc_media_t media;

  // Reset release synchroniser
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  assign suspend_flag_ok = i_stop || i_suspend;
  assign stop_ok = i_stop;
  assign wr_ok = i_wr && suspend_flag_ok;
  assign o_wr_refused = i_wr && !suspend_flag_ok;

  // Next mode word
  always_comb
  begin
    mode_d = mode_q;
    if (i_init_load)
      mode_d = i_init_mode;
    else if (wr_ok)
    begin
      mode_d = i_wdata;
      if (!stop_ok)
        mode_d[`MMC_BIT_INT_LB] = mode_q[`MMC_BIT_INT_LB];
    end
    mode_d[15:11] = 5'h00;
  end

  // Mode register
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= `MMC_MODE_RESET;
    else
      mode_q <= mode_d;
  end

  // Read path, internal loopback hidden unless stopped
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= 16'h0000;
    else if (suspend_flag_ok)
    begin
      o_rdata <= mode_q;
      o_rdata[`MMC_BIT_INT_LB] <= stop_ok & mode_q[`MMC_BIT_INT_LB];
    end
    else
      o_rdata <= 16'h0000;
  end

  mmc_mode_decode u_decode (
    .i_mode(mode_q),
    .i_media_sel(i_media_sel),
    .o_media(media)
  );

  // Registered medium settings
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_media <= '0;
      o_tx_dis <= 1'b0;
      o_rx_dis <= 1'b0;
    end
    else
    begin
      o_media <= media;
      o_tx_dis <= mode_q[`MMC_BIT_TX_DIS];
      o_rx_dis <= mode_q[`MMC_BIT_RX_DIS];
    end
  end

  mmc_retry_ctl u_retry (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_start(i_tx_start),
    .i_frame_fcs_force(i_frame_fcs_force),
    .i_fcs_dis(mode_q[`MMC_BIT_FCS_DIS]),
    .i_retry_dis(mode_q[`MMC_BIT_RETRY_DIS]),
    .i_coll_force(media.coll_force),
    .i_att_end(i_att_end),
    .i_att_coll(i_att_coll),
    .o_busy(o_tx_busy),
    .o_retry_att(o_retry_att),
    .o_res(o_tx_res)
  );

  AST_WR_HOLD: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_wr && !suspend_flag_ok && !i_init_load |=> mode_q == $past(mode_q))
    else $error("mode changed on refused write");
  AST_INTERNAL_LOOPBACK_HOLD: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_wr && i_suspend && !i_stop && !i_init_load |=>
      mode_q[`MMC_BIT_INT_LB] == $past(mode_q[`MMC_BIT_INT_LB]))
    else $error("internal loopback written while only suspended");
  AST_WR_TAKE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_wr && i_stop && !i_init_load |=> mode_q[10:0] == $past(i_wdata[10:0]))
    else $error("allowed write not stored");
  AST_PORT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !i_media_sel |-> media.port == mmc_port_t'(mode_q[`MMC_BIT_PORT_HI:`MMC_BIT_PORT_LO]))
    else $error("port select mismatch");
  AST_LB_EXT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    mode_q[`MMC_BIT_LB_EN] && !mode_q[`MMC_BIT_INT_LB] |-> ##1 o_media.lb == MMC_LB_EXT)
    else $error("external loopback misdecoded");

  // Access and transmit steps used by the checks below
  sequence s_wr_stopped;
    i_wr && i_stop && !i_init_load;
  endsequence
  sequence s_wr_suspended;
    i_wr && i_suspend && !i_stop && !i_init_load;
  endsequence
  sequence s_wr_refused;
    i_wr && !i_stop && !i_suspend && !i_init_load;
  endsequence
  sequence s_quiet;
    !i_wr && !i_init_load;
  endsequence
  sequence s_tx_last;
    o_tx_busy && i_att_end && !o_retry_att;
  endsequence
  sequence s_start_plain;
    !o_tx_busy && i_tx_start && !i_frame_fcs_force && !mode_q[`MMC_BIT_FCS_DIS];
  endsequence

  // Write access checks
  // refused flag
  AST_REFUSE_FLAG: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_wr_refused == (i_wr && !i_stop && !i_suspend))
    else $error("refused flag wrong");
  AST_SUSPEND_FLAG_HI: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_wr_suspended |=> mode_q[`MMC_BIT_CODEC_LB:`MMC_BIT_PORT_LO] == $past(i_wdata[10:7]))
    else $error("suspended write lost upper fields");
  AST_SUSPEND_FLAG_LO: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_wr_suspended |=> mode_q[`MMC_BIT_RETRY_DIS:`MMC_BIT_RX_DIS] == $past(i_wdata[5:0]))
    else $error("suspended write lost lower fields");
  AST_INTERNAL_LOOPBACK_STOP: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_wr_stopped |=> mode_q[`MMC_BIT_INT_LB] == $past(i_wdata[6]))
    else $error("internal loopback not written while stopped");
  AST_QUIET_HOLD: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_quiet |=> mode_q == $past(mode_q))
    else $error("mode changed without access");
  AST_REFUSE_QUIET: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_wr_refused ##1 s_quiet |=> mode_q == $past(mode_q, 2))
    else $error("refused write leaked into mode");
  AST_SUSPEND_FLAG_KEEP: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_wr_suspended ##1 s_quiet |=> mode_q[`MMC_BIT_INT_LB] == $past(mode_q[6], 2))
    else $error("internal loopback drifted after suspended write");
  AST_WR_KEEP: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_wr_stopped ##1 s_quiet |=> mode_q[10:0] == $past(i_wdata[10:0], 2))
    else $error("stopped write not kept");

  // Read path checks
  // stopped read
  AST_RD_STOP: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_stop |=> o_rdata == $past(mode_q))
    else $error("stopped read differs from mode");
  AST_RD_SUSPEND_FLAG: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_suspend && !i_stop |=> !o_rdata[`MMC_BIT_INT_LB])
    else $error("internal loopback visible while suspended");
  AST_RD_RUN: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !i_stop && !i_suspend |=> o_rdata == 16'h0000)
    else $error("mode visible while running");

  // Decode checks
  // settings registered
  AST_MEDIA_REG: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    1'h1 |=> o_media == $past(media))
    else $error("medium settings not registered");
  AST_PORT_AUTO: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_media_sel |-> media.port == MMC_PORT_AUI)
    else $error("automatic selection not honoured");
  AST_TP_ONLY: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    media.low_thresh |-> media.port == MMC_PORT_TP && !i_media_sel)
    else $error("threshold active off twisted pair");
  AST_TP_ON: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    mode_q[`MMC_BIT_LRT_AUI_IDLE_LEVEL_SEL] && !i_media_sel && mode_q[`MMC_BIT_PORT_HI:`MMC_BIT_PORT_LO] == 2'h1 |->
      media.low_thresh)
    else $error("threshold lost on twisted pair");
  AST_AUI_ONLY: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    media.aui_idle_high |-> media.port == MMC_PORT_AUI && !i_media_sel)
    else $error("idle level active off manual AUI");
  AST_AUI_ON: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    mode_q[`MMC_BIT_LRT_AUI_IDLE_LEVEL_SEL] && !i_media_sel && mode_q[`MMC_BIT_PORT_HI:`MMC_BIT_PORT_LO] == 2'h0 |->
      media.aui_idle_high)
    else $error("idle level lost on manual AUI");
  AST_COLL_QUAL: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    media.coll_force |-> mode_q[`MMC_BIT_COLL_FORCE] && mode_q[`MMC_BIT_LB_EN] && mode_q[`MMC_BIT_INT_LB])
    else $error("collision forced outside internal loopback");
  AST_COLL_ON: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    mode_q[`MMC_BIT_COLL_FORCE] && mode_q[`MMC_BIT_LB_EN] && mode_q[`MMC_BIT_INT_LB] |-> media.coll_force)
    else $error("collision force dropped in internal loopback");
  AST_FCS_RX: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    media.fcs_to_rx == mode_q[`MMC_BIT_FCS_DIS])
    else $error("CRC ownership wrong");
  AST_LB_NONE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !mode_q[`MMC_BIT_LB_EN] |-> ##1 o_media.lb == MMC_LB_NONE)
    else $error("loopback decoded while disabled");
  AST_LB_INT_CODEC: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    mode_q[`MMC_BIT_LB_EN] && mode_q[`MMC_BIT_INT_LB] && !mode_q[`MMC_BIT_CODEC_LB] |-> ##1 o_media.lb == MMC_LB_INT_CODEC)
    else $error("internal loopback with codec misdecoded");
  AST_LB_INT_NOCODEC: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    mode_q[`MMC_BIT_LB_EN] && mode_q[`MMC_BIT_INT_LB] && mode_q[`MMC_BIT_CODEC_LB] |->
      ##1 o_media.lb == MMC_LB_INT_NOCODEC)
    else $error("internal loopback without codec misdecoded");

  // Reset release checks
  // mode cleared
  AST_RST_MODE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> mode_q == `MMC_MODE_RESET)
    else $error("mode not cleared by reset");
  AST_RST_MEDIA: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> o_media == '0)
    else $error("medium settings not cleared by reset");
  AST_RST_RDATA: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> o_rdata == 16'h0000)
    else $error("read data not cleared by reset");

  // Transmit checks
  // retry qualified
  AST_RETRY_QUAL: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_retry_att |-> i_att_end && o_tx_busy && !mode_q[`MMC_BIT_RETRY_DIS])
    else $error("retry requested without cause");
  AST_BUSY_START: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !o_tx_busy && i_tx_start |=> o_tx_busy)
    else $error("frame start not taken");
  AST_BUSY_END: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_tx_last |=> !o_tx_busy && o_tx_res.done)
    else $error("frame did not finish");
  AST_ERR_DONE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_tx_res.retry_err |-> o_tx_res.done && !o_tx_res.ok)
    else $error("retry error with bad outcome");
  AST_FCS_PLAIN: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_start_plain |=> ##1 o_tx_res.fcs_append)
    else $error("FCS missing with generation enabled");
endmodule : mmc_mode_ctrl

// File: dv/mmc_medium_model.sv
`timescale 1ns/1ps
module mmc_medium_model
#(parameter int DLY = 4)
(
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_go, // Attempt begins
  input wire logic i_coll, // Collide on this attempt
  output logic o_att_end, // Attempt end pulse
  output logic o_att_coll // Collision of the attempt
);
  int cnt_q;
  // Times each attempt; the collision line toggles between answers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 0;
      o_att_end <= 1'h0;
      o_att_coll <= 1'h0;
    end
    else
    begin
      cnt_q <= i_go ? DLY : (cnt_q != 0 ? cnt_q - 1 : 0);
      o_att_end <= (cnt_q == 1);
      o_att_coll <= (cnt_q == 1) ? i_coll : ~o_att_coll;
    end
  end
endmodule : mmc_medium_model

// File: dv/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb
  import mmc_pkg::*;
;
  typedef struct packed {logic st; logic su; logic ms; logic [15:0] wd; logic [15:0] ex;} mmc_row_t;
  localparam mmc_row_t ROWS [11] = '{
    '{1'h1, 1'h0, 1'h0, 16'h0180, 16'h0180}, '{1'h1, 1'h0, 1'h0, 16'h0280, 16'h0280},
    '{1'h1, 1'h0, 1'h0, 16'h0300, 16'h0300}, '{1'h1, 1'h0, 1'h0, 16'h0200, 16'h0200},
    '{1'h1, 1'h0, 1'h1, 16'h0280, 16'h0280}, '{1'h0, 1'h1, 1'h0, 16'h0044, 16'h0004},
    '{1'h1, 1'h0, 1'h0, 16'h0454, 16'h0454}, '{1'h0, 1'h1, 1'h0, 16'h0010, 16'h0050},
    '{1'h1, 1'h0, 1'h0, 16'h0054, 16'h0054}, '{1'h0, 1'h0, 1'h0, 16'hFFFF, 16'h0054},
    '{1'h1, 1'h0, 1'h0, 16'hFFFF, 16'h07FF}};
  logic clk, arst_n, stop, susp, msel, init_ld, wr_s, tx_start, frame_fcs_force, coll;
  logic [15:0] init_md, wdata, rdata;
  logic refused, busy, retry_att, tx_dis, rx_dis, att_end, att_coll;
  mmc_tx_res_t tx_res;
  mmc_media_t media;
  int err_total = 0;
  int tests_run = 0;
  mmc_mode_ctrl i_mmc_mode_ctrl (.i_ref_clk(clk), .i_arst_n(arst_n), .i_stop(stop), .i_suspend(susp),
    .i_media_sel(msel), .i_init_load(init_ld), .i_init_mode(init_md), .i_wr(wr_s), .i_wdata(wdata),
    .o_rdata(rdata), .i_tx_start(tx_start), .i_frame_fcs_force(frame_fcs_force), .i_att_end(att_end),
    .i_att_coll(att_coll), .o_wr_refused(refused), .o_tx_busy(busy), .o_retry_att(retry_att),
    .o_tx_res(tx_res), .o_media(media), .o_tx_dis(tx_dis), .o_rx_dis(rx_dis));
  mmc_medium_model i_mmc_medium_model (.i_clk(clk), .i_rst_n(arst_n), .i_go(tx_start | retry_att),
    .i_coll(coll), .o_att_end(att_end), .o_att_coll(att_coll));
  // Free-running core clock
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Expected medium settings from a stored mode word
  function automatic mmc_media_t med(logic [15:0] m, logic ms);
    mmc_media_t r;
    r.port = ms ? MMC_PORT_AUI : mmc_port_t'(m[8:7]);
    r.lb = !m[2] ? MMC_LB_NONE : (!m[6] ? MMC_LB_EXT : (m[10] ? MMC_LB_INT_NOCODEC : MMC_LB_INT_CODEC));
    r.low_thresh = m[9] & (r.port == MMC_PORT_TP);
    r.aui_idle_high = m[9] & !ms & (r.port == MMC_PORT_AUI);
    r.coll_force = m[4] & m[2] & m[6];
    r.fcs_to_rx = m[3];
    return r;
  endfunction : med
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Reset pulse, then stopped read of cleared state
  task automatic do_reset;
    arst_n <= 1'h0;
    stop <= 1'h1;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("rst rdata", 16'h0000, rdata)
    `CHK("rst media", 8'h00, media)
    $display("reset test done");
  endtask : do_reset
  task automatic wr(logic st, logic su, logic ms, logic [15:0] d);
    @(posedge clk);
    stop <= st;
    susp <= su;
    msel <= ms;
    wr_s <= 1'h1;
    wdata <= d;
    #1;
    `CHK("refused", ~(st | su), refused)
    @(posedge clk);
    wr_s <= 1'h0;
  endtask : wr
  // One frame against the medium model; counts retry requests
  task automatic frame(logic [15:0] m, logic af, logic c, int nr, logic [3:0] ex);
    int n;
    int k;
    mmc_tx_res_t res;
    wr(1'h1, 1'h0, 1'h0, m);
    repeat (2) @(posedge clk);
    coll <= c;
    frame_fcs_force <= af;
    tx_start <= 1'h1;
    @(posedge clk);
    tx_start <= 1'h0;
    #1;
    `CHK("busy", 1'h1, busy)
    n = 0;
    k = 0;
    res = '0;
    while (res.done !== 1'h1 && k < 500)
    begin
      @(posedge clk);
      #1;
      if (retry_att === 1'h1)
        n++;
      res = tx_res;
      k++;
    end
    if (k >= 500)
    begin
      err_total++;
      tally_and_finish();
    end
    `CHK("retries", nr, n)
    `CHK("result", ex, res)
    $display("frame %h done", m);
  endtask : frame
  initial
  begin
    {arst_n, stop, susp, msel, init_ld, wr_s, tx_start, frame_fcs_force, coll} = '0;
    init_md = 16'h0000;
    wdata = 16'h0000;
    do_reset();
    foreach (ROWS[i])
    begin
      wr(ROWS[i].st, ROWS[i].su, ROWS[i].ms, ROWS[i].wd);
      stop <= 1'h1;
      susp <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("rdata", ROWS[i].ex, rdata)
      `CHK("media", med(ROWS[i].ex, ROWS[i].ms), media)
      `CHK("dis", ROWS[i].ex[1:0], {tx_dis, rx_dis})
      $display("row %0d done", i);
    end
    frame(16'h0000, 1'h0, 1'h0, 0, 4'hD);
    frame(16'h0000, 1'h0, 1'h1, 15, 4'hB);
    frame(16'h0020, 1'h0, 1'h1, 0, 4'hB);
    frame(16'h0008, 1'h0, 1'h0, 0, 4'hC);
    frame(16'h0008, 1'h1, 1'h0, 0, 4'hD);
    frame(16'h0054, 1'h0, 1'h0, 15, 4'hB);
    frame(16'h0010, 1'h0, 1'h0, 0, 4'hD);
    // Suspended read hides internal loopback; codec stays in the loop
    wr(1'h1, 1'h0, 1'h0, 16'h0054);
    stop <= 1'h0;
    susp <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("suspend_flag rdata", 16'h0014, rdata)
    `CHK("suspend_flag media", med(16'h0054, 1'h0), media)
    $display("suspend test done");
    // Init block load while running, then running read is blank
    @(posedge clk);
    stop <= 1'h0;
    susp <= 1'h0;
    init_ld <= 1'h1;
    init_md <= 16'h0300;
    @(posedge clk);
    init_ld <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("run rdata", 16'h0000, rdata)
    `CHK("init port", MMC_PORT_GENERAL_SERIAL_PORT, media.port)
    $display("init test done");
    @(posedge clk);
    do_reset();
    tally_and_finish();
  end
endmodule : tb
